// file: dv/oag_asserts.sv
// Port-level assertion checker for the operand address generator
`timescale 1ns/100ps
module oag_asserts
	import oag_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic start,
	input wire oag_mode_t mode,
	input wire logic word_op,
	input wire logic [7:0] imm_byte,
	input wire logic [15:0] sp_value,
	input wire logic done,
	input wire logic [15:0] eff_addr,
	input wire logic addr_is_sfr,
	input wire logic addr_fault
);
	// Captured request: mode, word flag, immediate, stack pointer
	logic busy_q, busy_d, take;
	logic [28:0] cap_q, cap_d;
	logic sh, sf, st;
	assign take = start && !busy_q && clk_en;
	assign sh = done && cap_q[28:25] == OAG_MODE_SHORT;
	assign sf = done && cap_q[28:25] == OAG_MODE_SFR;
	assign st = done && cap_q[28:25] == OAG_MODE_STACK;
	always_comb begin
		busy_d = take ? 1'b1 : (done ? 1'b0 : busy_q);
		cap_d = take ? {mode, word_op, imm_byte, sp_value} : cap_q;
	end
	always_ff @(posedge sys_clk) begin
		busy_q <= rst ? 1'b0 : busy_d;
		cap_q <= cap_d;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	chk_done_single: assert property (done |=> !done)
		else $error("done held longer than one cycle");
	chk_direct_late: assert property (
		take && mode == OAG_MODE_DIRECT |-> ##1 !done [*3] ##1 done)
		else $error("direct answer not four edges after request");
	chk_short_high: assert property (sh |->
		eff_addr[15:9] == 7'h7F && eff_addr[7:0] == cap_q[23:16])
		else $error("short address upper or lower bits wrong");
	chk_short_bit8: assert property (
		sh |-> eff_addr[8] == (cap_q[23:16] < 8'h20))
		else $error("short address bit 8 wrong");
	chk_short_sfr: assert property (
		sh |-> addr_is_sfr == (cap_q[23:16] <= 8'h1F))
		else $error("short window region flag wrong");
	chk_short_word: assert property (
		sh && cap_q[24] |-> addr_fault == cap_q[16])
		else $error("short word parity fault wrong");
	chk_sfr_addr: assert property (
		sf |-> eff_addr == {8'hFF, cap_q[23:16]} && addr_is_sfr)
		else $error("special register address wrong");
	chk_sfr_word: assert property (
		sf && cap_q[24] && cap_q[16] |-> addr_fault)
		else $error("odd word special register not faulted");
	chk_stack_addr: assert property (st |-> eff_addr == cap_q[15:0])
		else $error("stack address differs from pointer");
	chk_stack_ram: assert property (st |-> addr_fault ==
		(cap_q[15:0] < OAG_RAM_LO || cap_q[15:0] > OAG_RAM_HI))
		else $error("stack outside fast RAM not faulted");
endmodule : oag_asserts
bind oag_top oag_asserts oag_asserts_i (.sys_clk(sys_clk), .rst(rst),
	.clk_en(clk_en), .start(start), .mode(mode), .word_op(word_op),
	.imm_byte(imm_byte), .sp_value(sp_value), .done(done),
	.eff_addr(eff_addr), .addr_is_sfr(addr_is_sfr), .addr_fault(addr_fault));

// file: dv/oag_mem_model.sv
// Internal memory and special register space region map
`timescale 1ns/100ps
module oag_mem_model
	import oag_pkg::*;
(
	input wire logic [15:0] addr,
	output logic is_ram,
	output logic is_sfr
);
	assign is_ram = addr >= OAG_RAM_LO && addr <= OAG_RAM_HI;
	assign is_sfr = addr[15:8] == OAG_SFR_PAGE;
endmodule : oag_mem_model

// file: dv/tb.sv
// Self-checking bench for the operand address generator
`timescale 1ns/100ps
module tb;
	import oag_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic start = 1'b0;
	oag_mode_t mode = OAG_MODE_NONE;
	oag_imp_t imp_op = OAG_IMP_NONE;
	logic [7:0] opcode = 8'h00;
	logic word_op = 1'b0;
	logic [7:0] imm_byte = 8'h00;
	logic idx_sel_c = 1'b0;
	logic [1:0] bank = 2'h0;
	logic [15:0] sp_value = 16'h0000;
	logic result_wr = 1'b0;
	logic [15:0] result_word = 16'h0000;
	logic done, addr_is_sfr, addr_is_ram, addr_fault, m_ram, m_sfr;
	logic [15:0] eff_addr, acc_pair_write, pair_operand;
	logic [15:0] exp_addr = 16'h0000;
	logic [7:0] acc_write, reg_operand;
	logic [7:0] regs [4][8] = '{default: 8'h00};
	logic [31:0] seed = 32'h0000_0062;
	int failures = 0;
	int num_checks = 0;
	always #25 sys_clk = ~sys_clk;
	oag_top oag_top_i (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.start(start), .mode(mode), .imp_op(imp_op), .opcode(opcode),
		.word_op(word_op), .imm_byte(imm_byte), .idx_sel_c(idx_sel_c),
		.bank_select_low(bank[0]), .bank_select_high(bank[1]),
		.sp_value(sp_value), .result_wr(result_wr),
		.result_word(result_word), .done(done), .eff_addr(eff_addr),
		.addr_is_sfr(addr_is_sfr), .addr_is_ram(addr_is_ram),
		.addr_fault(addr_fault), .acc_write(acc_write),
		.acc_pair_write(acc_pair_write), .reg_operand(reg_operand),
		.pair_operand(pair_operand));
	oag_mem_model oag_mem_model_i (.addr(exp_addr), .is_ram(m_ram),
		.is_sfr(m_sfr));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic op(input oag_mode_t m, input logic [7:0] oc,
		input logic [7:0] lo, input logic [7:0] hi);
		int n;
		logic [1:0] pr;
		logic [15:0] pv, base;
		logic sw;
		@(posedge sys_clk) #1;
		mode = m;
		opcode = oc;
		imm_byte = lo;
		start = 1'b1;
		@(posedge sys_clk) #1;
		start = 1'b0;
		if (m == OAG_MODE_DIRECT) begin
			// Low byte must stay until the high byte slot
			@(posedge sys_clk) #1;
			@(posedge sys_clk) #1;
			imm_byte = hi;
		end
		n = 0;
		while (done !== 1'b1 && n < 8) begin
			@(posedge sys_clk) #1;
			n++;
		end
		check(done, 16'h0001);
		pr = (oc == OAG_OP_LOAD_THIRD) ? OAG_PAIR_THIRD : oc[2:1];
		pv = {regs[bank][2 * pr + 1], regs[bank][2 * pr]};
		base = {regs[bank][7], regs[bank][6]};
		sw = m == OAG_MODE_SHORT || m == OAG_MODE_SFR;
		case (m)
			OAG_MODE_DIRECT: exp_addr = {hi, lo};
			OAG_MODE_SHORT: exp_addr = {7'h7F, lo < 8'h20, lo};
			OAG_MODE_SFR: exp_addr = {8'hFF, lo};
			OAG_MODE_INDIRECT: exp_addr = pv;
			OAG_MODE_BASED: exp_addr = base + {8'h00, lo};
			OAG_MODE_INDEXED: exp_addr = base +
				{8'h00, idx_sel_c ? regs[bank][2] : regs[bank][3]};
			OAG_MODE_STACK: exp_addr = sp_value;
			default: exp_addr = 16'h0000;
		endcase
		#1;
		check(eff_addr, exp_addr);
		check(addr_is_ram, m_ram);
		check(addr_is_sfr, sw & m_sfr);
		check(addr_fault, (sw & word_op & lo[0])
			| (m == OAG_MODE_SFR && lo inside {[8'hD0 : 8'hDF]})
			| (m == OAG_MODE_STACK && !m_ram));
		check(acc_write, regs[bank][1]);
		check(acc_pair_write, {regs[bank][1], regs[bank][0]});
		if (m == OAG_MODE_REG) begin
			check(reg_operand, regs[bank][oc[2:0]]);
			check(pair_operand, pv);
		end
	endtask : op
	task automatic wr(input logic [15:0] w);
		@(posedge sys_clk) #1;
		result_word = w;
		result_wr = 1'b1;
		@(posedge sys_clk) #1;
		result_wr = 1'b0;
		regs[bank][0] = w[7:0];
		regs[bank][1] = w[15:8];
	endtask : wr
	initial begin
		logic [31:0] r;
		logic [7:0] bv [6];
		logic [15:0] sv [6];
		oag_mode_t md;
		bv = '{8'h1F, 8'h20, 8'hCF, 8'hD0, 8'hDF, 8'hE1};
		sv = '{16'hFAFF, 16'hFB00, 16'hFEFF, 16'hFF00, 16'hFB01, 16'h0000};
		repeat (6) @(posedge sys_clk);
		#1 rst = 1'b0;
		word_op = 1'b1;
		foreach (bv[k]) begin
			sp_value = sv[k];
			op(OAG_MODE_SHORT, 8'h00, bv[k], 8'h00);
			op(OAG_MODE_SFR, 8'h00, bv[k], 8'h00);
			op(OAG_MODE_STACK, 8'h00, bv[k], 8'h00);
		end
		// Low enable must hold a pending short answer back
		@(posedge sys_clk) #1;
		mode = OAG_MODE_SHORT;
		imm_byte = 8'h42;
		start = 1'b1;
		@(posedge sys_clk) #1;
		start = 1'b0;
		clk_en = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		check(done, 16'h0000);
		clk_en = 1'b1;
		@(posedge sys_clk) #1;
		check(done, 16'h0001);
		check(eff_addr, 16'hFE42);
		for (int i = 0; i < 240; i++) begin
			seed = xs(seed);
			r = seed;
			bank = r[1:0];
			word_op = r[2];
			idx_sel_c = r[3];
			sp_value = {r[4] ? 8'hFD : r[31:24], r[23:16]};
			imp_op = oag_imp_t'(3'(r[7:5] % 3'h6 + 3'h1));
			md = oag_mode_t'(4'(i % 9 + 1));
			op(md, r[15:8], r[23:16], r[31:24]);
			if (md == OAG_MODE_IMPLIED && imp_op <= OAG_IMP_DIV)
				wr(r[31:16]);
		end
		test_done();
	end
	initial begin
		#200_000;
		failures++;
		test_done();
	end
endmodule : tb

// file: rtl/oag_pkg.sv
// Constants and types for the operand address generator
package oag_pkg;

	// Addressing modes requested by the decoder
	typedef enum logic [3:0] {
		OAG_MODE_NONE,
		OAG_MODE_IMPLIED,
		OAG_MODE_REG,
		OAG_MODE_DIRECT,
		OAG_MODE_SHORT,
		OAG_MODE_SFR,
		OAG_MODE_INDIRECT,
		OAG_MODE_BASED,
		OAG_MODE_INDEXED,
		OAG_MODE_STACK
	} oag_mode_t;

	// Implied-operand operations
	typedef enum logic [2:0] {
		OAG_IMP_NONE,
		OAG_IMP_MUL,
		OAG_IMP_DIV,
		OAG_IMP_ADJ_ADD,
		OAG_IMP_ADJ_SUB,
		OAG_IMP_ROT_R,
		OAG_IMP_ROT_L
	} oag_imp_t;

	// Operand fetch sequencer states
	typedef enum logic [1:0] {
		OAG_ST_IDLE,
		OAG_ST_LOW,
		OAG_ST_HIGH,
		OAG_ST_DONE
	} oag_state_t;

	localparam int OAG_NUM_BANKS = 4;
	localparam int OAG_NUM_REGS = 8;
	// Byte register codes in a bank
	localparam logic [2:0] OAG_REG_X = 3'h0;
	localparam logic [2:0] OAG_REG_A = 3'h1;
	localparam logic [2:0] OAG_REG_C = 3'h2;
	localparam logic [2:0] OAG_REG_B = 3'h3;
	// Pair codes
	localparam logic [1:0] OAG_PAIR_ACC = 2'h0;
	localparam logic [1:0] OAG_PAIR_THIRD = 2'h2;
	localparam logic [1:0] OAG_PAIR_BASE = 2'h3;
	// Opcode loading accumulator through the third pair
	localparam logic [7:0] OAG_OP_LOAD_THIRD = 8'h85;
	// Opcode field position of register code
	localparam int OAG_RFIELD_LSB = 0;
	// Short direct window and special register page
	localparam logic [7:0] OAG_SHORT_SFR_TOP = 8'h1F;
	localparam logic [6:0] OAG_SHORT_HI = 7'h7F;
	localparam logic [7:0] OAG_SFR_PAGE = 8'hFF;
	localparam logic [7:0] OAG_SFR_GAP_LO = 8'hD0;
	localparam logic [7:0] OAG_SFR_GAP_HI = 8'hDF;
	// Internal fast RAM bounds (covers lower short window, FE20-FEFF)
	localparam logic [15:0] OAG_RAM_LO = 16'hFB00;
	localparam logic [15:0] OAG_RAM_HI = 16'hFEFF;
	// Reset values
	localparam logic [15:0] OAG_SP_RESET = 16'hFEFF;
	localparam logic [15:0] OAG_ADDR_RESET = 16'h0000;

endpackage : oag_pkg

// file: rtl/oag_regfile.sv
// Banked general register file: four banks of eight bytes
`timescale 1ns/100ps
module oag_regfile
	import oag_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	oag_regfile_if.bank_file rf
);

	logic [7:0] mem_q [OAG_NUM_BANKS][OAG_NUM_REGS];
	logic [7:0] mem_d [OAG_NUM_BANKS][OAG_NUM_REGS];

	always_comb begin
		mem_d = mem_q;
		if (rf.wr_en) begin
			mem_d[rf.bank][rf.wr_sel] = rf.wr_data;
		end
		if (rf.wr_pair_en) begin
			mem_d[rf.bank][{rf.wr_pair_sel, 1'b0}] = rf.wr_pair_data[7:0];
			mem_d[rf.bank][{rf.wr_pair_sel, 1'b1}] = rf.wr_pair_data[15:8];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int b = 0; b < OAG_NUM_BANKS; b++) begin
				for (int r = 0; r < OAG_NUM_REGS; r++) begin
					mem_q[b][r] <= 8'h00;
				end
			end
		end else if (clk_en) begin
			mem_q <= mem_d;
		end
	end

	assign rf.byte_data = mem_q[rf.bank][rf.byte_sel]; // RULE4
	// Pair n is bytes 2n (low) and 2n+1 (high)
	// Spelled out, not a function, so reads follow every register write
	assign rf.pair_data = {mem_q[rf.bank][{rf.pair_sel, 1'b1}],
		mem_q[rf.bank][{rf.pair_sel, 1'b0}]}; // RULE5
	assign rf.base_data = {mem_q[rf.bank][{rf.base_sel, 1'b1}],
		mem_q[rf.bank][{rf.base_sel, 1'b0}]};
	assign rf.idx_b = mem_q[rf.bank][OAG_REG_B];
	assign rf.idx_c = mem_q[rf.bank][OAG_REG_C];
	assign rf.acc_byte = mem_q[rf.bank][OAG_REG_A];
	assign rf.acc_pair = {mem_q[rf.bank][{OAG_PAIR_ACC, 1'b1}],
		mem_q[rf.bank][{OAG_PAIR_ACC, 1'b0}]};

endmodule : oag_regfile

// file: rtl/oag_regfile_if.sv
// Register file read and write carrier between generator and register bank
`timescale 1ns/100ps
interface oag_regfile_if;
	import oag_pkg::*;
	logic [1:0] bank;
	logic [2:0] byte_sel;
	logic [1:0] pair_sel;
	logic [1:0] base_sel;
	logic [7:0] byte_data;
	logic [15:0] pair_data;
	logic [15:0] base_data;
	logic [7:0] idx_b;
	logic [7:0] idx_c;
	logic [7:0] acc_byte;
	logic [15:0] acc_pair;
	logic wr_en;
	logic [2:0] wr_sel;
	logic [7:0] wr_data;
	logic wr_pair_en;
	logic [1:0] wr_pair_sel;
	logic [15:0] wr_pair_data;
	modport gen (
		output bank, byte_sel, pair_sel, base_sel, wr_en, wr_sel, wr_data,
		output wr_pair_en, wr_pair_sel, wr_pair_data,
		input byte_data, pair_data, base_data, idx_b, idx_c,
		input acc_byte, acc_pair
	);
	modport bank_file (
		input bank, byte_sel, pair_sel, base_sel, wr_en, wr_sel, wr_data,
		input wr_pair_en, wr_pair_sel, wr_pair_data,
		output byte_data, pair_data, base_data, idx_b, idx_c,
		output acc_byte, acc_pair
	);
endinterface : oag_regfile_if

// file: rtl/oag_top.sv
// Operand address generator with banked register file
//
// Behaviour
// RULE1 - Multiply reads accumulator byte, writes 16-bit product to accumulator pair
// RULE2 - Word divide uses accumulator pair for dividend and quotient
// RULE3 - Decimal adjust and nibble rotates operate on accumulator byte
// RULE4 - Byte register chosen by 3-bit opcode field within active bank
// RULE5 - Eight byte registers per bank, four 16-bit pairs
// RULE6 - Two bank select flags choose the active bank
// RULE7 - Direct address: 16-bit immediate, low byte fetched first
// RULE8 - Short direct reaches a 256-byte window with one byte
// RULE9 - Short window: FE20-FEFF fast RAM, FF00-FF1F special registers
// RULE10 - Address bit 8 is zero for 20-FF, one for 00-1F
// RULE11 - Short address bits 15..9 ones, bits 7..0 the immediate
// RULE12 - Short-direct word operands must be at even addresses
// RULE13 - Special register address is FF page plus immediate, gap excluded
// RULE14 - Word special register access only at even addresses
// RULE15 - Register indirect uses selected pair as full address
// RULE16 - Opcode 85 loads accumulator through the third pair
// RULE17 - Based: base pair plus zero-extended offset, carry dropped
// RULE18 - Based indexed: base pair plus B or C, carry dropped
// RULE19 - Stack operations address through the stack pointer
// RULE20 - Stack accesses reach only internal fast RAM
`timescale 1ns/100ps
module oag_top
	import oag_pkg::*;
(
	sys_clk,
	rst,
	clk_en,
	start,
	mode,
	imp_op,
	opcode,
	word_op,
	imm_byte,
	idx_sel_c,
	bank_select_low,
	bank_select_high,
	sp_value,
	result_wr,
	result_word,
	done,
	eff_addr,
	addr_is_sfr,
	addr_is_ram,
	addr_fault,
	acc_write,
	acc_pair_write,
	reg_operand,
	pair_operand
);
	input wire logic sys_clk;
	input wire logic rst;
	input wire logic clk_en;
	input wire logic start;
	input wire oag_mode_t mode;
	input wire oag_imp_t imp_op;
	input wire logic [7:0] opcode;
	input wire logic word_op;
	input wire logic [7:0] imm_byte;
	input wire logic idx_sel_c;
	input wire logic bank_select_low;
	input wire logic bank_select_high;
	input wire logic [15:0] sp_value;
	input wire logic result_wr;
	input wire logic [15:0] result_word;
	output logic done;
	output logic [15:0] eff_addr;
	output logic addr_is_sfr;
	output logic addr_is_ram;
	output logic addr_fault;
	output logic [7:0] acc_write;
	output logic [15:0] acc_pair_write;
	output logic [7:0] reg_operand;
	output logic [15:0] pair_operand;

	//////////////////////////////////////////////////////////////////////
	oag_regfile_if rf ();

	oag_regfile u_regfile (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.rf(rf.bank_file)
	);

	//////////////////////////////////////////////////////////////////////
	oag_state_t state_q, state_d;
	oag_mode_t mode_q, mode_d;
	oag_imp_t imp_q, imp_d;
	logic [7:0] op_q, op_d;
	logic word_q, word_d;
	logic idx_c_q, idx_c_d;
	logic [7:0] lo_q, lo_d;
	logic [15:0] addr_d;
	logic sfr_d, ram_d, fault_d, done_d;
	logic [7:0] acc_d, reg_d;
	logic [15:0] accp_d, pair_d;
	logic [15:0] addr_q;
	logic sfr_q, ram_q, fault_q, done_q;
	logic [7:0] acc_q, reg_q;
	logic [15:0] accp_q, pair_q;
	logic [15:0] offset;
	logic imp_byte_src, imp_pair_src, imp_pair_dst;

	// Bank comes straight from the status flags every cycle
	assign rf.bank = {bank_select_high, bank_select_low}; // RULE6
	assign rf.byte_sel = op_q[OAG_RFIELD_LSB +: 3]; // RULE4
	// Fixed third pair for the dedicated load opcode
	assign rf.pair_sel = (op_q == OAG_OP_LOAD_THIRD) ?
		OAG_PAIR_THIRD : op_q[2:1]; // RULE16
	assign rf.base_sel = OAG_PAIR_BASE;
	// Multiply and divide results land in the accumulator pair; byte writes are tied off
	assign rf.wr_en = 1'b0;
	assign rf.wr_sel = OAG_REG_A;
	assign rf.wr_data = 8'h00;
	assign rf.wr_pair_en = result_wr && clk_en &&
		(mode_q == OAG_MODE_IMPLIED) && imp_pair_dst; // RULE1 RULE2
	assign rf.wr_pair_sel = OAG_PAIR_ACC;
	assign rf.wr_pair_data = result_word;

	// Offset is zero-extended; sum truncated to 16 bits
	assign offset = (mode_q == OAG_MODE_INDEXED) ?
		{8'h00, (idx_c_q ? rf.idx_c : rf.idx_b)} : // RULE18
		{8'h00, lo_q}; // RULE17

	function automatic logic in_ram(input logic [15:0] a);
		in_ram = (a >= OAG_RAM_LO) && (a <= OAG_RAM_HI);
	endfunction : in_ram

	//////////////////////////////////////////////////////////////////////
	// Implied operations name the accumulator without an operand field
	always_comb begin
		imp_byte_src = 1'b0;
		imp_pair_src = 1'b0;
		imp_pair_dst = 1'b0;
		case (imp_q)
		OAG_IMP_MUL: begin
			imp_byte_src = 1'b1; // RULE1
			imp_pair_dst = 1'b1; // RULE1
		end
		OAG_IMP_DIV: begin
			imp_pair_src = 1'b1; // RULE2
			imp_pair_dst = 1'b1; // RULE2
		end
		OAG_IMP_ADJ_ADD, OAG_IMP_ADJ_SUB: begin
			imp_byte_src = 1'b1; // RULE3
		end
		OAG_IMP_ROT_R, OAG_IMP_ROT_L: begin
			imp_byte_src = 1'b1; // RULE3
		end
		default: begin
			imp_byte_src = 1'b0;
		end
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		imp_d = imp_q;
		op_d = op_q;
		word_d = word_q;
		idx_c_d = idx_c_q;
		lo_d = lo_q;
		addr_d = addr_q;
		sfr_d = sfr_q;
		ram_d = ram_q;
		fault_d = fault_q;
		done_d = 1'b0;
		acc_d = acc_q;
		accp_d = accp_q;
		reg_d = reg_q;
		pair_d = pair_q;
		case (state_q)
		OAG_ST_IDLE: begin
			if (start) begin
				mode_d = mode;
				imp_d = imp_op;
				op_d = opcode;
				word_d = word_op;
				idx_c_d = idx_sel_c;
				lo_d = imm_byte;
				state_d = (mode == OAG_MODE_DIRECT) ? OAG_ST_LOW : OAG_ST_DONE;
			end
		end
		OAG_ST_LOW: begin
			// Low byte first, high byte read in the done step two steps later
			lo_d = imm_byte; // RULE7
			state_d = OAG_ST_HIGH;
		end
		OAG_ST_HIGH: begin
			state_d = OAG_ST_DONE;
		end
		OAG_ST_DONE: begin
			fault_d = 1'b0;
			sfr_d = 1'b0;
			addr_d = OAG_ADDR_RESET;
			acc_d = rf.acc_byte;
			accp_d = rf.acc_pair;
			reg_d = rf.byte_data;
			pair_d = rf.pair_data;
			case (mode_q)
			OAG_MODE_IMPLIED: begin
				// Accumulator byte and pair are always the operands
				if (imp_byte_src) begin
					acc_d = rf.acc_byte; // RULE1 RULE3
				end
				if (imp_pair_src) begin
					accp_d = rf.acc_pair; // RULE2
				end
			end
			OAG_MODE_REG: begin
				reg_d = rf.byte_data; // RULE4 RULE5
			end
			OAG_MODE_DIRECT: begin
				addr_d = {imm_byte, lo_q}; // RULE7
			end
			OAG_MODE_SHORT: begin
				addr_d = {OAG_SHORT_HI,
					(lo_q <= OAG_SHORT_SFR_TOP), lo_q}; // RULE8 RULE10 RULE11
				sfr_d = (lo_q <= OAG_SHORT_SFR_TOP); // RULE9
				fault_d = word_q && lo_q[0]; // RULE12
			end
			OAG_MODE_SFR: begin
				addr_d = {OAG_SFR_PAGE, lo_q}; // RULE13
				sfr_d = 1'b1;
				fault_d = ((lo_q >= OAG_SFR_GAP_LO) &&
					(lo_q <= OAG_SFR_GAP_HI)) ||
					(word_q && lo_q[0]); // RULE13 RULE14
			end
			OAG_MODE_INDIRECT: begin
				addr_d = rf.pair_data; // RULE15 RULE16
			end
			OAG_MODE_BASED, OAG_MODE_INDEXED: begin
				addr_d = rf.base_data + offset; // RULE17 RULE18
			end
			OAG_MODE_STACK: begin
				addr_d = sp_value; // RULE19
				fault_d = !in_ram(sp_value); // RULE20
			end
			default: begin
				addr_d = OAG_ADDR_RESET;
			end
			endcase
			ram_d = in_ram(addr_d);
			done_d = 1'b1;
			state_d = OAG_ST_IDLE;
		end
		default: begin
			state_d = OAG_ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= OAG_ST_IDLE;
			mode_q <= OAG_MODE_NONE;
			imp_q <= OAG_IMP_NONE;
			op_q <= 8'h00;
			word_q <= 1'b0;
			idx_c_q <= 1'b0;
			lo_q <= 8'h00;
			addr_q <= OAG_ADDR_RESET;
			sfr_q <= 1'b0;
			ram_q <= 1'b0;
			fault_q <= 1'b0;
			done_q <= 1'b0;
			acc_q <= 8'h00;
			accp_q <= 16'h0000;
			reg_q <= 8'h00;
			pair_q <= 16'h0000;
		end else if (clk_en) begin
			state_q <= state_d;
			mode_q <= mode_d;
			imp_q <= imp_d;
			op_q <= op_d;
			word_q <= word_d;
			idx_c_q <= idx_c_d;
			lo_q <= lo_d;
			addr_q <= addr_d;
			sfr_q <= sfr_d;
			ram_q <= ram_d;
			fault_q <= fault_d;
			done_q <= done_d;
			acc_q <= acc_d;
			accp_q <= accp_d;
			reg_q <= reg_d;
			pair_q <= pair_d;
		end
	end

	assign done = done_q;
	assign eff_addr = addr_q;
	assign addr_is_sfr = sfr_q;
	assign addr_is_ram = ram_q;
	assign addr_fault = fault_q;
	assign acc_write = acc_q;
	assign acc_pair_write = accp_q;
	assign reg_operand = reg_q;
	assign pair_operand = pair_q;

endmodule : oag_top
